/* design/rxfb_guard.sv */
// Receive frame buffer guard: empty indicator, overwrite protection, delimiter match
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module rxfb_guard (
  input wire logic clock_i,
  input wire logic nrst_i,
  input rxfb_pkg::rxfb_bus_req_t bus_i,
  output logic [7:0] rdata_o,
  input wire logic sel_n_i,
  input wire logic fb_read_cmd_i,
  input wire logic fb_data_ready_i,
  input wire logic host_fb_wr_i,
  input rxfb_pkg::rxfb_trx_state_t trx_state_i,
  input wire logic extended_mode_i,
  input wire logic [7:0] rx_detect_threshold_i,
  input rxfb_pkg::rxfb_radio_t radio_i,
  input wire logic preamble_last_i,
  output logic irq_pin_o,
  output logic fb_radio_wr_o,
  output logic [7:0] fb_radio_data_o,
  output logic rx_frame_done_event_o,
  output logic tx_bit_o,
  output logic tx_bit_valid_o,
  output logic delim_low_nibble_zero_o
);
  import rxfb_pkg::*;

  typedef struct packed {
    logic [1:0] sel_sync;
    logic sel_n;
    logic [7:0] ctrl_one;
    logic [7:0] ctrl_two;
    logic [7:0] sof_delim;
    logic [NUM_EVENTS-1:0] irq_status;
    logic [NUM_EVENTS-1:0] irq_mask;
    logic [7:0] rdata;
    logic fb_read_active;
    logic protected_q;
    logic in_frame_blocked;
    rxfb_sync_state_t sync;
    logic irq_pin;
    logic fb_wr;
    logic [7:0] fb_data;
    logic done_ev;
    logic delim_warn;
    logic tx_bit;
    logic tx_valid;
  } rxfb_guard_st_t;

  rxfb_guard_st_t st_ff;
  rxfb_guard_st_t nxt_st;
  logic ser_bit;
  logic ser_valid;
  logic sel_rise;
  logic rx_state;
  logic protect_en;
  logic [NUM_EVENTS-1:0] ev;
  logic frame_good;

  // ----------------------------------------
  // Transmit delimiter
  // ----------------------------------------
  rxfb_sof_tx u_sof_tx (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .preamble_last_i(preamble_last_i),
    .delim_i(st_ff.sof_delim),
    .bit_o(ser_bit),
    .bit_valid_o(ser_valid)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    ev = '0;
    nxt_st.sel_sync = {st_ff.sel_sync[0], sel_n_i};
    nxt_st.sel_n = st_ff.sel_sync[1];
    sel_rise = st_ff.sel_sync[1] & ~st_ff.sel_n;
    rx_state = (trx_state_i == TRX_RX_ON) || (trx_state_i == TRX_RX_AUTO_ACK);
    // Threshold input deliberately unused here
    protect_en = st_ff.ctrl_two[BIT_PROTECT_EN] && rx_state;
    frame_good = extended_mode_i ? radio_i.frame_end : (radio_i.frame_end && radio_i.fcs_ok);

    // Register writes
    if (bus_i.wr) begin
      unique case (bus_i.addr)
        REG_CTRL_ONE: nxt_st.ctrl_one = bus_i.wdata;
        REG_CTRL_TWO: nxt_st.ctrl_two = bus_i.wdata;
        REG_SOF_DELIM: nxt_st.sof_delim = bus_i.wdata;
        REG_IRQ_MASK: nxt_st.irq_mask = bus_i.wdata[NUM_EVENTS-1:0];
        REG_IRQ_STATUS: nxt_st.irq_status = st_ff.irq_status & ~bus_i.wdata[NUM_EVENTS-1:0];
        default: ;
      endcase
    end

    // Register reads
    nxt_st.rdata = 8'h00;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        REG_CTRL_ONE: nxt_st.rdata = st_ff.ctrl_one;
        REG_CTRL_TWO: nxt_st.rdata = st_ff.ctrl_two;
        REG_SOF_DELIM: nxt_st.rdata = st_ff.sof_delim;
        REG_IRQ_MASK: nxt_st.rdata = {4'h0, st_ff.irq_mask};
        REG_IRQ_STATUS: nxt_st.rdata = {4'h0, st_ff.irq_status};
        REG_GUARD_STATUS: nxt_st.rdata = {5'h00, st_ff.sync == SYN_PAYLOAD, st_ff.fb_read_active, st_ff.protected_q};
        default: nxt_st.rdata = 8'h00;
      endcase
    end

    // Buffer read window, command to deselect
    if (fb_read_cmd_i && !st_ff.sel_n) begin
      nxt_st.fb_read_active = 1'b1;
    end else if (sel_rise) begin
      nxt_st.fb_read_active = 1'b0;
    end

    // Frame sync and radio write path
    nxt_st.fb_wr = 1'b0;
    nxt_st.done_ev = 1'b0;
    if (!rx_state) begin
      nxt_st.sync = SYN_HUNT;
    end else begin
      unique case (st_ff.sync)
        SYN_HUNT: begin
          if (radio_i.octet_valid && radio_i.octet == st_ff.sof_delim) begin
            nxt_st.sync = SYN_WAIT_PHR;
            nxt_st.in_frame_blocked = st_ff.protected_q;
          end
        end
        SYN_WAIT_PHR: begin
          if (radio_i.phr_valid) begin
            nxt_st.sync = SYN_PAYLOAD;
            ev[EV_RX_START] = 1'b1;
          end else if (radio_i.rx_error) begin
            nxt_st.sync = SYN_HUNT;
          end
        end
        SYN_PAYLOAD: begin
          if (radio_i.octet_valid && !st_ff.in_frame_blocked) begin
            nxt_st.fb_wr = 1'b1;
            nxt_st.fb_data = radio_i.octet;
          end
          if (radio_i.frame_end || radio_i.rx_error) begin
            nxt_st.sync = SYN_HUNT;
            nxt_st.done_ev = radio_i.frame_end && !st_ff.in_frame_blocked;
            ev[EV_FRAME_DONE] = radio_i.frame_end && !st_ff.in_frame_blocked;
            ev[EV_FRAME_DROPPED] = st_ff.in_frame_blocked;
            if (frame_good && protect_en && !st_ff.in_frame_blocked) begin
              nxt_st.protected_q = 1'b1;
            end
          end
        end
        default: nxt_st.sync = SYN_HUNT;
      endcase
    end

    // Protection release; host writes are never gated
    if (st_ff.protected_q && ((sel_rise && st_ff.fb_read_active) || !protect_en)) begin
      nxt_st.protected_q = 1'b0;
      ev[EV_PROT_RELEASE] = 1'b1;
    end

    // Sticky status, set wins over clear
    nxt_st.irq_status = nxt_st.irq_status | ev;

    // Interrupt pin role
    if (st_ff.ctrl_one[BIT_EMPTY_IND_EN] && st_ff.fb_read_active) begin
      nxt_st.irq_pin = ~fb_data_ready_i | radio_i.rx_error | (st_ff.irq_pin & ~fb_data_ready_i);
    end else begin
      nxt_st.irq_pin = |(nxt_st.irq_status & st_ff.irq_mask);
    end

    nxt_st.delim_warn = (st_ff.sof_delim[3:0] == SOF_LOW_NIBBLE_ZERO);

    // Serial delimiter bit retimed onto the output flops
    nxt_st.tx_bit = ser_bit;
    nxt_st.tx_valid = ser_valid;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= '0;
      st_ff.sel_sync <= 2'b11;
      st_ff.sel_n <= 1'b1;
      st_ff.ctrl_one <= CTRL_RST;
      st_ff.ctrl_two <= CTRL_RST;
      st_ff.sof_delim <= SOF_DELIM_RST;
      st_ff.protected_q <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata_o = st_ff.rdata;
  assign irq_pin_o = st_ff.irq_pin;
  assign fb_radio_wr_o = st_ff.fb_wr;
  assign fb_radio_data_o = st_ff.fb_data;
  assign rx_frame_done_event_o = st_ff.done_ev;
  assign tx_bit_o = st_ff.tx_bit;
  assign tx_bit_valid_o = st_ff.tx_valid;
  assign delim_low_nibble_zero_o = st_ff.delim_warn;
endmodule

/* design/rxfb_pkg.sv */
// Package with register map, fields, states and carriers for the receive frame buffer guard
package rxfb_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL_ONE = 8'h04;
  localparam logic [7:0] REG_SOF_DELIM = 8'h0B;
  localparam logic [7:0] REG_CTRL_TWO = 8'h0C;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h0E;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0F;
  localparam logic [7:0] REG_GUARD_STATUS = 8'h10;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int BIT_EMPTY_IND_EN = 4;
  localparam int BIT_PROTECT_EN = 7;
  localparam logic [7:0] SOF_DELIM_RST = 8'hA7;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] SOF_LOW_NIBBLE_ZERO = 4'h0;
  localparam int NUM_EVENTS = 4;
  localparam int EV_RX_START = 0;
  localparam int EV_FRAME_DONE = 1;
  localparam int EV_FRAME_DROPPED = 2;
  localparam int EV_PROT_RELEASE = 3;
  localparam logic [7:0] SYM_PER_OCTET = 8'h02;

  // ----------------------------------------
  // Transceiver states
  // ----------------------------------------
  typedef enum logic [2:0] {
    TRX_OFF = 3'b000,
    TRX_RX_ON = 3'b001,
    TRX_RX_AUTO_ACK = 3'b010,
    TRX_TX = 3'b011,
    TRX_OTHER = 3'b100
  } rxfb_trx_state_t;

  // Receive-side frame sync machine
  typedef enum logic [1:0] {
    SYN_HUNT = 2'b00,
    SYN_WAIT_PHR = 2'b01,
    SYN_PAYLOAD = 2'b10
  } rxfb_sync_state_t;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rxfb_bus_req_t;

  typedef struct packed {
    logic octet_valid;
    logic [7:0] octet;
    logic phr_valid;
    logic frame_end;
    logic fcs_ok;
    logic rx_error;
  } rxfb_radio_t;

  typedef struct packed {
    logic fb_read_cmd;
    logic sel_n;
    logic fb_data_ready;
  } rxfb_spi_t;

endpackage

/* design/rxfb_sof_tx.sv */
// Delimiter serialiser for the transmit path, low bit first
`timescale 1ns/1ps
module rxfb_sof_tx (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic preamble_last_i,
  input wire logic [7:0] delim_i,
  output logic bit_o,
  output logic bit_valid_o
);
  import rxfb_pkg::*;

  typedef struct packed {
    logic [7:0] shift;
    logic [3:0] cnt;
    logic bit_q;
    logic valid;
  } rxfb_sof_tx_st_t;

  rxfb_sof_tx_st_t st_ff;
  rxfb_sof_tx_st_t nxt_st;

  // ----------------------------------------
  // Serialiser
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.valid = 1'b0;
    if (preamble_last_i) begin
      nxt_st.shift = delim_i;
      nxt_st.cnt = 4'h8;
    end else if (st_ff.cnt != 4'h0) begin
      nxt_st.bit_q = st_ff.shift[0];
      nxt_st.valid = 1'b1;
      nxt_st.shift = {1'b0, st_ff.shift[7:1]};
      nxt_st.cnt = st_ff.cnt - 4'h1;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bit_o = st_ff.bit_q;
  assign bit_valid_o = st_ff.valid;
endmodule

/* verification/rxfb_guard_asserts.sv */
// Port checks for the receive frame buffer guard
`timescale 1ns/1ps
module rxfb_guard_asserts
  import rxfb_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input rxfb_pkg::rxfb_bus_req_t bus_i,
  input wire logic [7:0] rdata_o,
  input wire logic sel_n_i,
  input wire logic fb_read_cmd_i,
  input wire logic fb_data_ready_i,
  input rxfb_pkg::rxfb_trx_state_t trx_state_i,
  input rxfb_pkg::rxfb_radio_t radio_i,
  input wire logic preamble_last_i,
  input wire logic irq_pin_o,
  input wire logic fb_radio_wr_o,
  input wire logic [7:0] fb_radio_data_o,
  input wire logic rx_frame_done_event_o,
  input wire logic tx_bit_valid_o
);
  // --
  // Indicator window
  // --
  logic en_ff;
  logic win_ff;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en_ff <= 1'b0;
      win_ff <= 1'b0;
    end else begin
      if (bus_i.wr && bus_i.addr == REG_CTRL_ONE) begin
        en_ff <= bus_i.wdata[BIT_EMPTY_IND_EN];
      end
      win_ff <= !sel_n_i && (win_ff || (en_ff && fb_read_cmd_i));
    end
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  chk_tx_run: assert property (preamble_last_i |-> ##3 tx_bit_valid_o [*8] ##1 !tx_bit_valid_o)
    else $error("delimiter run wrong");
  chk_tx_cause: assert property ($rose(tx_bit_valid_o) |-> $past(preamble_last_i, 3))
    else $error("delimiter without preamble end");
  chk_wr_cause: assert property (fb_radio_wr_o |-> $past(radio_i.octet_valid))
    else $error("stray buffer write");
  chk_wr_data: assert property (fb_radio_wr_o |-> fb_radio_data_o == $past(radio_i.octet))
    else $error("buffer byte wrong");
  chk_wr_state: assert property (fb_radio_wr_o |-> $past(trx_state_i) inside {TRX_RX_ON, TRX_RX_AUTO_ACK})
    else $error("write outside receive");
  chk_done_cause: assert property (rx_frame_done_event_o |-> $past(radio_i.frame_end))
    else $error("frame done without end");
  chk_rdata_idle: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
    else $error("read data outside slot");
  chk_ind_ready: assert property (win_ff && fb_data_ready_i |=> !irq_pin_o)
    else $error("pin high with data ready");
  chk_ind_empty: assert property (win_ff && !fb_data_ready_i |=> irq_pin_o)
    else $error("pin low with buffer empty");
endmodule
bind rxfb_guard rxfb_guard_asserts u_chk (.clock_i, .nrst_i, .bus_i, .rdata_o, .sel_n_i, .fb_read_cmd_i,
  .fb_data_ready_i, .trx_state_i, .radio_i, .preamble_last_i, .irq_pin_o, .fb_radio_wr_o, .fb_radio_data_o,
  .rx_frame_done_event_o, .tx_bit_valid_o);

/* verification/rxfb_guard_tb.sv */
// Testbench for the receive frame buffer guard
`timescale 1ns/1ps
module rxfb_guard_tb;
  import rxfb_pkg::*;
  logic clock_i, nrst_i, go, rdy, pre, ext, hw, irq, fw, txb, txv, nib, sel_n, cmd, busy, abrt;
  logic [7:0] rdata, thr, txs;
  rxfb_bus_req_t bus;
  rxfb_trx_state_t st;
  rxfb_radio_t rad;
  int n_mismatch, checks_done, nwr;
  rxfb_guard dut (.clock_i, .nrst_i, .bus_i(bus), .rdata_o(rdata), .sel_n_i(sel_n), .fb_read_cmd_i(cmd),
    .fb_data_ready_i(rdy), .host_fb_wr_i(hw), .trx_state_i(st), .extended_mode_i(ext),
    .rx_detect_threshold_i(thr), .radio_i(rad), .preamble_last_i(pre), .irq_pin_o(irq), .fb_radio_wr_o(fw),
    .fb_radio_data_o(), .rx_frame_done_event_o(), .tx_bit_o(txb), .tx_bit_valid_o(txv),
    .delim_low_nibble_zero_o(nib));
  rxfb_host_model #(.WAIT_LIMIT(64)) host (.clock_i, .start_i(go), .irq_pin_i(irq), .sel_n_o(sel_n),
    .cmd_o(cmd), .busy_o(busy), .aborted_o(abrt));
  always @(posedge clock_i) nwr <= nwr + int'(fw);
  always @(posedge clock_i) if (txv) txs <= {txb, txs[7:1]};
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clock_i);
    bus <= '0;
    @(posedge clock_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m, input string nm);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock_i);
    bus <= '0;
    @(posedge clock_i);
    chk(nm, rdata & m, e);
  endtask
  task automatic pin(input logic [7:0] e);
    repeat (2) @(posedge clock_i);
    chk("irq", 8'(irq), e);
  endtask
  task automatic frame(input logic [7:0] dl, input logic ok, input int n, input int e);
    int n0;
    n0 = nwr;
    rad <= '{1'b1, dl, 1'b0, 1'b0, 1'b0, 1'b0};
    @(posedge clock_i);
    rad <= '{1'b0, 8'h00, 1'b1, 1'b0, 1'b0, 1'b0};
    for (int i = 0; i < n; i++) begin
      @(posedge clock_i);
      rad <= '{1'b1, 8'h10 + 8'(i), 1'b0, 1'b0, 1'b0, 1'b0};
    end
    @(posedge clock_i);
    rad <= '{1'b0, 8'h00, 1'b0, 1'b1, ok, 1'b0};
    @(posedge clock_i);
    rad <= '0;
    repeat (3) @(posedge clock_i);
    chk("writes", 8'(nwr - n0), 8'(e));
  endtask
  task automatic host_read(input logic r, input logic e);
    rdy <= r;
    go <= 1'b1;
    @(posedge clock_i);
    go <= 1'b0;
    @(posedge clock_i);
    for (int i = 0; i < 300 && busy; i++) @(posedge clock_i);
    repeat (4) @(posedge clock_i);
    chk("abort", 8'(abrt), 8'(e));
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  initial begin
    #50000;
    n_mismatch++;
    test_done();
  end
  initial begin
    {nrst_i, go, rdy, pre, ext, hw, bus, rad, thr, txs, nwr} = '0;
    st = TRX_RX_ON;
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    rd(REG_SOF_DELIM, SOF_DELIM_RST, 8'hFF, "delim");
    rd(REG_CTRL_ONE, CTRL_RST, 8'hFF, "ctrl1");
    rd(REG_CTRL_TWO, CTRL_RST, 8'hFF, "ctrl2");
    rd(8'h20, 8'h00, 8'hFF, "unmapped");
    wr(REG_SOF_DELIM, 8'h50);
    rd(REG_SOF_DELIM, 8'h50, 8'hFF, "delim");
    chk("nibble", 8'(nib), 8'h01);
    frame(8'hA7, 1'b1, 3, 0);
    frame(8'h50, 1'b1, 3, 3);
    rd(REG_IRQ_STATUS, 8'h03, 8'hFF, "status");
    pin(8'h00);
    wr(REG_IRQ_MASK, 8'h0F);
    pin(8'h01);
    wr(REG_IRQ_STATUS, 8'h0F);
    wr(REG_IRQ_MASK, 8'h00);
    pin(8'h00);
    wr(REG_SOF_DELIM, SOF_DELIM_RST);
    frame(8'hA7, 1'b1, 2, 2);
    chk("nibble", 8'(nib), 8'h00);
    frame(8'hA7, 1'b1, 2, 2);
    $display("sync and overwrite done");
    wr(REG_CTRL_TWO, 8'h80);
    thr <= 8'hFF;
    frame(8'hA7, 1'b1, 2, 2);
    rd(REG_GUARD_STATUS, 8'h01, 8'h01, "guard");
    frame(8'hA7, 1'b1, 2, 0);
    rd(REG_IRQ_STATUS, 8'h04, 8'h04, "dropped");
    wr(REG_IRQ_STATUS, 8'h0F);
    host_read(1'b1, 1'b0);
    rd(REG_GUARD_STATUS, 8'h00, 8'h01, "guard");
    frame(8'hA7, 1'b1, 2, 2);
    st <= TRX_OFF;
    @(posedge clock_i);
    st <= TRX_RX_AUTO_ACK;
    repeat (2) @(posedge clock_i);
    rd(REG_GUARD_STATUS, 8'h00, 8'h01, "guard");
    frame(8'hA7, 1'b0, 2, 2);
    frame(8'hA7, 1'b0, 2, 2);
    ext <= 1'b1;
    frame(8'hA7, 1'b0, 2, 2);
    frame(8'hA7, 1'b0, 2, 0);
    nrst_i <= 1'b0;
    @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    wr(REG_CTRL_TWO, 8'h80);
    rd(REG_GUARD_STATUS, 8'h00, 8'h01, "guard");
    frame(8'hA7, 1'b1, 2, 2);
    $display("protection done");
    wr(REG_IRQ_MASK, 8'h0F);
    host_read(1'b1, 1'b1);
    wr(REG_CTRL_ONE, 8'h10);
    host_read(1'b1, 1'b0);
    host_read(1'b0, 1'b1);
    pin(8'h01);
    $display("indicator done");
    pre <= 1'b1;
    @(posedge clock_i);
    pre <= 1'b0;
    repeat (12) @(posedge clock_i);
    chk("txbits", txs, SOF_DELIM_RST);
    $display("transmit done");
    test_done();
  end
endmodule

/* verification/rxfb_host_model.sv */
// Host model reading the frame buffer
`timescale 1ns/1ps
module rxfb_host_model #(
  parameter int WAIT_LIMIT = 64
) (
  input wire logic clock_i,
  input wire logic start_i,
  input wire logic irq_pin_i,
  output logic sel_n_o,
  output logic cmd_o,
  output logic busy_o,
  output logic aborted_o
);
  int got;
  int idle;
  initial begin
    {sel_n_o, cmd_o, busy_o, aborted_o} = 4'b1000;
    forever begin
      @(posedge clock_i);
      if (start_i) begin
        busy_o <= 1'b1;
        sel_n_o <= 1'b0;
        repeat (3) @(posedge clock_i);
        cmd_o <= 1'b1;
        @(posedge clock_i);
        cmd_o <= 1'b0;
        @(posedge clock_i);
        got = 0;
        idle = 0;
        while (got < 2 && idle <= WAIT_LIMIT) begin
          @(posedge clock_i);
          if (irq_pin_i) idle++;
          else got++;
        end
        aborted_o <= idle > WAIT_LIMIT;
        sel_n_o <= 1'b1;
        busy_o <= 1'b0;
      end
    end
  end
endmodule
